// file: src/splk_pkg.sv
package splk_pkg;

   // ------------------------------------------------------------
   // Geometry and widths
   // ------------------------------------------------------------
   localparam int unsigned NUM_SECTORS = 16;
   localparam int unsigned SEC_W       = 4;
   localparam int unsigned PASS_W      = 64;
   localparam int unsigned CNT_W       = 14;

   // ------------------------------------------------------------
   // Reset and factory values
   // ------------------------------------------------------------
   localparam logic [NUM_SECTORS-1:0] GUARD_ERASED = {NUM_SECTORS{1'b1}};
   localparam logic [NUM_SECTORS-1:0] VGUARD_RST   = {NUM_SECTORS{1'b1}};
   localparam logic [PASS_W-1:0]      PASS_BLANK   = {PASS_W{1'b1}};
   localparam logic [PASS_W-1:0]      PASS_HIDDEN  = {PASS_W{1'b0}};
   localparam logic [SEC_W-1:0]       BOOT_SECTOR  = 4'h0;

   // ------------------------------------------------------------
   // Protection method field encodings
   // ------------------------------------------------------------
   localparam logic [1:0] METHOD_NONE    = 2'h3;
   localparam logic [1:0] METHOD_PERSIST = 2'h2;
   localparam logic [1:0] METHOD_PASSWD  = 2'h1;
   localparam logic [1:0] METHOD_ILLEGAL = 2'h0;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_PS   = 8000;
   localparam int unsigned UNLOCK_DELAY_US = 100;
   localparam int unsigned UNLOCK_TOL_US   = 20;
   localparam int unsigned UNLOCK_DELAY_CYC = (UNLOCK_DELAY_US * 1000000) / CLK_PERIOD_PS;

   // ------------------------------------------------------------
   // Command and state types
   // ------------------------------------------------------------
   typedef enum logic [7:0] {
      SPLK_OP_NONE     = 8'h00,
      SPLK_OP_VG_WR    = 8'h01,
      SPLK_OP_G_PROG   = 8'h02,
      SPLK_OP_G_ERASE  = 8'h04,
      SPLK_OP_LK_CLR   = 8'h08,
      SPLK_OP_UNLOCK   = 8'h10,
      SPLK_OP_PW_PROG  = 8'h20,
      SPLK_OP_PW_READ  = 8'h40,
      SPLK_OP_METHOD   = 8'h80
   } splk_op_t;

   typedef struct packed {
      splk_op_t          op;
      logic [SEC_W-1:0]  sector;
      logic              value;
      logic [PASS_W-1:0] data;
   } splk_cmd_t;

   typedef enum logic [1:0] {
      SPLK_IDLE  = 2'h1,
      SPLK_DELAY = 2'h2
   } splk_fsm_t;

   typedef struct packed {
      logic [NUM_SECTORS-1:0] vguard;
      logic [NUM_SECTORS-1:0] pguard;
      logic                   lock;
      logic [1:0]             method;
      logic [PASS_W-1:0]      pass;
      logic [PASS_W-1:0]      pass_rd;
      logic                   busy;
      logic                   perr;
      logic                   done;
      logic [CNT_W-1:0]       cnt;
      splk_fsm_t              fsm;
   } splk_state_t;

endpackage : splk_pkg

// file: src/splk_sector_lock.sv
`timescale 1ns/1ps
// Summary of operation
// [RULE_01] One volatile guard per sector, freely rewritten.
// [RULE_02] Volatile guard matters only when persistent is 1.
// [RULE_03] Unprotected only when both guards are 1.
// [RULE_04] Guard lock 0 freezes all persistent guards.
// [RULE_05] Lock clear command drives guard lock to 0.
// [RULE_06] Host clears lock after configuring persistent guards.
// [RULE_07] Persistent method: reset sets lock, no re-set.
// [RULE_08] Software reset leaves guard lock untouched.
// [RULE_09] Password method: reset clears lock, unlock sets.
// [RULE_10] Unlock compares full 64 bits, exact match.
// [RULE_11] Mismatch sets error, keeps busy, lock stays 0.
// [RULE_12] Unlock accepted at most once per 100 us; a software reset ends the hold-off early here.
// [RULE_13] Correct password releases busy without delay.
// [RULE_14] Password programming only clears bits, silently.
// [RULE_15] Blank password storage reads all ones.
// [RULE_16] Password method ignores password program and read.
// [RULE_17] Method bits are one-time programmable, never erased.
// [RULE_18] Read protection forces addresses to boot sector.
// [RULE_19] Volatile guards reset; persistent guards retained.
// [RULE_20] Host selects protection method last in manufacture.
// [RULE_21] Host may freeze secure region at boot.
// [RULE_22] Locked persistent program or erase fails unchanged.
// [RULE_23] Method field: 11 none, 10 persistent, 01 password.
// [RULE_24] Final protection ORs range and guard protection.
// [RULE_25] Access to protected sector rejected with error.
module splk_sector_lock
   import splk_pkg::*;
#(
   parameter int unsigned UNLOCK_CYC = UNLOCK_DELAY_CYC
) (
   input  wire logic                   mclk,
   input  wire logic                   sys_rst,
   input  wire logic                   nv_blank,
   input  wire logic                   sw_rst,
   input  wire splk_cmd_t              cmd,
   input  wire logic                   err_clr,
   input  wire logic [NUM_SECTORS-1:0] range_protect,
   input  wire logic                   array_req,
   input  wire logic [SEC_W-1:0]       array_sector,
   input  wire logic                   read_protect,
   input  wire logic [SEC_W-1:0]       ecc_sector,
   output logic [NUM_SECTORS-1:0]      sector_protected,
   output logic                        array_ok,
   output logic [NUM_SECTORS-1:0]      volatile_sector_guard,
   output logic [NUM_SECTORS-1:0]      persistent_sector_guard,
   output logic                        guard_lock,
   output logic [1:0]                  protection_method_reg,
   output logic [PASS_W-1:0]           pass_rd_data,
   output logic                        busy_flag,
   output logic                        prog_err,
   output logic                        cmd_done,
   output logic [SEC_W-1:0]            ecc_sector_eff,
   output logic                        ecc_allowed
);

   // ------------------------------------------------------------
   // Helper functions
   // ------------------------------------------------------------
   function automatic logic is_passwd(input logic [1:0] m);
      is_passwd = (m == METHOD_PASSWD);
   endfunction : is_passwd

   function automatic logic [NUM_SECTORS-1:0] guard_prot(
      input logic [NUM_SECTORS-1:0] pg,
      input logic [NUM_SECTORS-1:0] vg
   );
      guard_prot = ~(pg & vg);
   endfunction : guard_prot

   // Only a blank field may take a selection, and only a single-zero code.
   // Asking for both zeros is refused as illegal.
   function automatic logic method_pick_ok(
      input logic [1:0] cur,
      input logic [1:0] req
   );
      method_pick_ok = (cur == METHOD_NONE) &&
                       ((req == METHOD_PERSIST) || (req == METHOD_PASSWD));
   endfunction : method_pick_ok

   // The lock comes up open in every method but the password one.
   // The method is the one that survives this reset.
   function automatic logic lock_after_reset(input logic [1:0] m);
      lock_after_reset = !is_passwd(m);
   endfunction : lock_after_reset

   // Read protection leaves only the boot sector readable.
   function automatic logic sector_readable(
      input logic             rp,
      input logic [SEC_W-1:0] sec
   );
      sector_readable = !rp || (sec == BOOT_SECTOR);
   endfunction : sector_readable

   // Programming only pulls bits low; a one over a zero is dropped quietly.
   function automatic logic [PASS_W-1:0] pass_prog(
      input logic [PASS_W-1:0] old_pw,
      input logic [PASS_W-1:0] new_pw
   );
      pass_prog = old_pw & new_pw;
   endfunction : pass_prog

   // Each guard is programmed to zero alone; erase restores all ones.
   function automatic logic [NUM_SECTORS-1:0] guard_clear(
      input logic [NUM_SECTORS-1:0] pg,
      input logic [SEC_W-1:0]       sec
   );
      guard_clear      = pg;
      guard_clear[sec] = 1'b0;
   endfunction : guard_clear

   localparam logic [CNT_W-1:0] UNLOCK_LAST = CNT_W'(UNLOCK_CYC - 1);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   splk_state_t            st_r;
   splk_state_t            st_nxt;
   logic [NUM_SECTORS-1:0] prot_all;
   logic                   cmd_live;
   logic [SEC_W-1:0]       cmd_sector;
   logic                   cmd_value;
   logic [PASS_W-1:0]      cmd_data;
   logic [1:0]             method_req;
   logic                   pass_match;
   logic                   hold_last;

   // ------------------------------------------------------------
   // Protection map
   // ------------------------------------------------------------
   // Range and guard protection are merged once and shared by all users.
   // [RULE_02] guard combining
   // [RULE_03] both guards open
   // [RULE_24] range OR guards
   assign prot_all = range_protect | guard_prot(st_r.pguard, st_r.vguard);

   // ------------------------------------------------------------
   // Command acceptance
   // ------------------------------------------------------------
   // New commands are held off while a failed unlock is timing out.
   assign cmd_live = (cmd.op != SPLK_OP_NONE) && !st_r.busy;

   // ------------------------------------------------------------
   // Command fields
   // ------------------------------------------------------------
   // Fields are split out so the command decode reads plainly.
   assign cmd_sector = cmd.sector;
   assign cmd_value  = cmd.value;
   assign cmd_data   = cmd.data;
   assign method_req = cmd.data[1:0];
   // [RULE_10] full width compare
   // The whole word is compared at once, so no partial match leaks out.
   assign pass_match = (cmd_data == st_r.pass);

   // [RULE_12] hold-off end
   assign hold_last = (st_r.cnt == UNLOCK_LAST);

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      st_nxt      = st_r;
      st_nxt.done = 1'b0;
      array_ok    = 1'b0;

      // ---------------------------------------------------------
      // Error flag and array check
      // ---------------------------------------------------------
      // A clear and a new error in one cycle leave the error set.
      if (err_clr) begin
         st_nxt.perr = 1'b0;
      end

      // [RULE_25] reject protected access
      if (array_req) begin
         if (prot_all[array_sector]) begin
            st_nxt.perr = 1'b1;
         end else begin
            array_ok = 1'b1;
         end
      end

      // ---------------------------------------------------------
      // Command execution
      // ---------------------------------------------------------
      unique case (st_r.fsm)
         SPLK_IDLE: begin
            if (cmd_live) begin
               st_nxt.done = 1'b1;
               unique case (cmd.op)
                  SPLK_OP_VG_WR: begin
                     // [RULE_01] volatile guard write
                     st_nxt.vguard[cmd_sector] = cmd_value;
                  end
                  SPLK_OP_G_PROG: begin
                     // [RULE_04] lock gates program
                     // [RULE_22] locked program fails
                     if (st_r.lock) begin
                        st_nxt.pguard = guard_clear(st_r.pguard, cmd_sector);
                     end else begin
                        st_nxt.perr = 1'b1;
                     end
                  end
                  SPLK_OP_G_ERASE: begin
                     // [RULE_22] locked erase fails
                     if (st_r.lock) begin
                        st_nxt.pguard = GUARD_ERASED;
                     end else begin
                        st_nxt.perr = 1'b1;
                     end
                  end
                  SPLK_OP_LK_CLR: begin
                     // [RULE_05] clear guard lock
                     st_nxt.lock = 1'b0;
                  end
                  SPLK_OP_UNLOCK: begin
                     if (is_passwd(st_r.method)) begin
                        // [RULE_10] full width compare
                        if (pass_match) begin
                           // [RULE_13] no delay on match
                           st_nxt.lock = 1'b1;
                        end else begin
                           // [RULE_11] mismatch error path
                           // Error and busy rise together for one failed try.
                           st_nxt.perr = 1'b1;
                           st_nxt.busy = 1'b1;
                           st_nxt.done = 1'b0;
                           st_nxt.cnt  = '0;
                           st_nxt.fsm  = SPLK_DELAY;
                        end
                     end
                  end
                  SPLK_OP_PW_PROG: begin
                     // [RULE_16] ignored in password method
                     if (!is_passwd(st_r.method)) begin
                        // [RULE_14] only clears bits
                        st_nxt.pass = pass_prog(st_r.pass, cmd_data);
                     end
                  end
                  SPLK_OP_PW_READ: begin
                     // [RULE_16] read blocked once selected
                     // Zeros stand in for undefined data, so nothing leaks.
                     if (is_passwd(st_r.method)) begin
                        st_nxt.pass_rd = '0;
                     end else begin
                        st_nxt.pass_rd = st_r.pass;
                     end
                  end
                  SPLK_OP_METHOD: begin
                     // [RULE_17] one-time selection
                     // [RULE_23] legal encodings only
                     if (method_pick_ok(st_r.method, method_req)) begin
                        st_nxt.method = method_req;
                     end else if (method_req != METHOD_NONE) begin
                        st_nxt.perr = 1'b1;
                     end
                  end
                  default: begin
                     st_nxt.done = 1'b0;
                  end
               endcase
            end
         end
         SPLK_DELAY: begin
            // [RULE_12] anti-guessing hold-off
            // Busy stays up so the host polls instead of retrying.
            if (hold_last) begin
               st_nxt.busy = 1'b0;
               st_nxt.done = 1'b1;
               st_nxt.fsm  = SPLK_IDLE;
            end else begin
               st_nxt.cnt = st_r.cnt + CNT_W'(1);
            end
         end
      endcase

      // ---------------------------------------------------------
      // Software reset
      // ---------------------------------------------------------
      // It comes last, so a command taken in the same cycle keeps only its persistent guard, method, password program and password read results.
      // [RULE_08] software reset keeps lock
      // [RULE_19] volatile guards reset to all ones
      if (sw_rst) begin
         st_nxt.vguard  = VGUARD_RST;
         st_nxt.busy    = 1'b0;
         st_nxt.perr    = 1'b0;
         st_nxt.done    = 1'b0;
         st_nxt.cnt     = '0;
         st_nxt.fsm     = SPLK_IDLE;
         st_nxt.lock    = st_r.lock;
      end
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   // The non-volatile fields only return to factory values when the
   // storage is reported blank; otherwise they ride through reset.
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         // [RULE_19] volatile guards reset
         st_r.vguard  <= VGUARD_RST;
         // [RULE_07] persistent method sets lock
         // [RULE_09] password method clears lock
         st_r.lock    <= lock_after_reset(nv_blank ? METHOD_NONE : st_r.method);
         st_r.pass_rd <= '0;
         st_r.busy    <= 1'b0;
         st_r.perr    <= 1'b0;
         st_r.done    <= 1'b0;
         st_r.cnt     <= '0;
         st_r.fsm     <= SPLK_IDLE;
         if (nv_blank) begin
            st_r.pguard <= GUARD_ERASED;
            st_r.method <= METHOD_NONE;
            // [RULE_15] blank password all ones
            st_r.pass   <= PASS_BLANK;
         end
      end else begin
         st_r <= st_nxt;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign sector_protected        = prot_all;
   assign volatile_sector_guard   = st_r.vguard;
   assign persistent_sector_guard = st_r.pguard;
   assign guard_lock              = st_r.lock;
   assign protection_method_reg   = st_r.method;
   assign pass_rd_data            = st_r.pass_rd;
   assign busy_flag               = st_r.busy;
   assign prog_err                = st_r.perr;
   assign cmd_done                = st_r.done;

   // ------------------------------------------------------------
   // Read protection
   // ------------------------------------------------------------
   // [RULE_18] boot sector forcing
   assign ecc_sector_eff = read_protect ? BOOT_SECTOR : ecc_sector;
   assign ecc_allowed    = sector_readable(read_protect, ecc_sector);

endmodule : splk_sector_lock

// file: testbench/splk_sector_lock_props.sv
`timescale 1ns/1ps
// ----------------------------------------------------------
// Sector lock checker
// ----------------------------------------------------------
module splk_sector_lock_props
   import splk_pkg::*;
#(
   parameter int unsigned UNLOCK_CYC = UNLOCK_DELAY_CYC
) (
   input wire logic                   mclk,
   input wire logic                   sys_rst,
   input wire logic                   sw_rst,
   input wire splk_cmd_t              cmd,
   input wire logic [NUM_SECTORS-1:0] range_protect,
   input wire logic                   array_req,
   input wire logic [SEC_W-1:0]       array_sector,
   input wire logic [NUM_SECTORS-1:0] sector_protected,
   input wire logic                   array_ok,
   input wire logic [NUM_SECTORS-1:0] volatile_sector_guard,
   input wire logic [NUM_SECTORS-1:0] persistent_sector_guard,
   input wire logic                   guard_lock,
   input wire logic [1:0]             protection_method_reg,
   input wire logic                   busy_flag,
   input wire logic                   prog_err
);
   // The delay tolerance is applied here so a retimed counter still passes.
   localparam int unsigned LO = UNLOCK_CYC * 4 / 5;
   localparam int unsigned HI = UNLOCK_CYC * 6 / 5;
   logic [CNT_W-1:0] busy_cnt_r;
   logic [CNT_W-1:0] busy_cnt_nxt;
   wire logic        take = !busy_flag && !sw_rst;

   always_comb busy_cnt_nxt = busy_flag ? busy_cnt_r + 1'b1 : '0;
   always_ff @(posedge mclk) busy_cnt_r <= sys_rst ? '0 : busy_cnt_nxt;

   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);

   a_prot_combine:
      assert property (sector_protected == (range_protect | ~(persistent_sector_guard & volatile_sector_guard)))
      else $error("sector protection wrong");
   a_vg_write:
      assert property (cmd.op == SPLK_OP_VG_WR && take |=> volatile_sector_guard[$past(cmd.sector)] == $past(cmd.value))
      else $error("volatile guard not written");
   a_lock_clear:
      assert property (cmd.op == SPLK_OP_LK_CLR && take |=> !guard_lock)
      else $error("lock not cleared");
   a_lock_stays:
      assert property (!guard_lock && protection_method_reg != METHOD_PASSWD |=> !guard_lock)
      else $error("lock set again");
   a_pguard_frozen:
      assert property (!guard_lock |=> $stable(persistent_sector_guard))
      else $error("locked guard changed");
   a_unlock_result:
      assert property (cmd.op == SPLK_OP_UNLOCK && take && !guard_lock && protection_method_reg == METHOD_PASSWD
                       |=> (busy_flag && prog_err && !guard_lock) || (guard_lock && !busy_flag))
      else $error("unlock outcome wrong");
   a_busy_span:
      assert property ($fell(busy_flag) && !$past(sw_rst) && !$past(sys_rst) |-> busy_cnt_r >= LO && busy_cnt_r <= HI)
      else $error("unlock delay out of range");
   a_array_deny:
      assert property (array_req && sector_protected[array_sector] |-> !array_ok ##1 prog_err)
      else $error("protected access not refused");
   a_swrst_keep:
      assert property (sw_rst |=> guard_lock == $past(guard_lock) && volatile_sector_guard == VGUARD_RST)
      else $error("software reset effect wrong");

   c_unlock_fail: cover property ($fell(busy_flag));
   c_lock_clear: cover property ($fell(guard_lock));
   c_array_deny: cover property (array_req && !array_ok);
endmodule : splk_sector_lock_props

bind splk_sector_lock splk_sector_lock_props #(.UNLOCK_CYC(UNLOCK_CYC)) i_props (
   .mclk, .sys_rst, .sw_rst, .cmd, .range_protect, .array_req, .array_sector, .sector_protected, .array_ok,
   .volatile_sector_guard, .persistent_sector_guard, .guard_lock, .protection_method_reg, .busy_flag, .prog_err
);

// file: testbench/splk_host_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------
// Host command model
// ----------------------------------------------------------
module splk_host_model
   import splk_pkg::*;
(
   input  wire logic mclk,
   input  wire logic busy_flag,
   output splk_cmd_t cmd
);
   initial cmd = '0;

   // Polls busy first, since commands offered while busy are dropped silently.
   task automatic send(input splk_op_t op, input logic [SEC_W-1:0] sec, input logic val,
                       input logic [PASS_W-1:0] data);
      while (busy_flag !== 1'b0) @(posedge mclk) #1;
      @(posedge mclk);
      #1 cmd = '{op, sec, val, data};
      @(posedge mclk);
      #1 cmd = '0;
   endtask : send
endmodule : splk_host_model

// file: testbench/tb_top.sv
`timescale 1ns/1ps
// ----------------------------------------------------------
// Sector lock bench
// ----------------------------------------------------------
module tb_top
   import splk_pkg::*;
;
   localparam int unsigned UCYC = 20;
   logic                   mclk = 1'b0;
   logic                   sys_rst, nv_blank, sw_rst = 1'b0, err_clr = 1'b0;
   logic                   array_req = 1'b0, read_protect = 1'b0;
   logic [SEC_W-1:0]       array_sector = '0, ecc_sector = 4'h5, ecc_sector_eff;
   logic [NUM_SECTORS-1:0] range_protect = '0, sector_protected, volatile_sector_guard, persistent_sector_guard;
   logic                   array_ok, guard_lock, busy_flag, prog_err, cmd_done, ecc_allowed;
   logic [1:0]             protection_method_reg;
   logic [PASS_W-1:0]      pass_rd_data;
   logic [PASS_W-1:0]      pw = 64'h0123_4567_0000_cdef;
   splk_cmd_t              cmd;
   int                     fail_count = 0, samples_checked = 0, cyc = 0, n;

   always #4 mclk = ~mclk;

   splk_sector_lock #(.UNLOCK_CYC(UCYC)) i_dut (
      .mclk, .sys_rst, .nv_blank, .sw_rst, .cmd, .err_clr, .range_protect, .array_req, .array_sector,
      .read_protect, .ecc_sector, .sector_protected, .array_ok, .volatile_sector_guard, .persistent_sector_guard,
      .guard_lock, .protection_method_reg, .pass_rd_data, .busy_flag, .prog_err, .cmd_done, .ecc_sector_eff,
      .ecc_allowed
   );
   splk_host_model i_host (.mclk, .busy_flag, .cmd);

   task automatic chk(input string name, input logic [PASS_W-1:0] seen, input logic [PASS_W-1:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   task automatic final_report();
      $display("Checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : final_report

   task automatic hw_reset(input logic blank);
      nv_blank = blank;
      sys_rst = 1'b1;
      repeat (8) @(posedge mclk);
      #1 sys_rst = 1'b0;
   endtask : hw_reset

   task automatic pulse(ref logic sig);
      sig = 1'b1;
      @(posedge mclk);
      #1 sig = 1'b0;
   endtask : pulse

   task automatic arr(input logic [SEC_W-1:0] s, input logic ok);
      array_req = 1'b1;
      array_sector = s;
      #1 chk("array ok", array_ok, ok);
      @(posedge mclk);
      #1 array_req = 1'b0;
      chk("array err", prog_err, !ok);
      pulse(err_clr);
   endtask : arr

   // The run takes under a hundred cycles; this ceiling only catches a hang.
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 3000) begin
         fail_count++;
         final_report();
      end
   end

   initial begin
      // freeze is host business; never driven here.
      hw_reset(1'b1);
      chk("vguard", volatile_sector_guard, VGUARD_RST);
      chk("pguard", persistent_sector_guard, GUARD_ERASED);
      chk("lock", guard_lock, 1'b1);
      chk("method", protection_method_reg, METHOD_NONE);
      i_host.send(SPLK_OP_PW_READ, '0, 1'b0, '0);
      chk("pass blank", pass_rd_data, PASS_BLANK);
      i_host.send(SPLK_OP_VG_WR, 4'h5, 1'b0, '0);
      chk("prot5", sector_protected, 16'h0020);
      i_host.send(SPLK_OP_VG_WR, 4'h5, 1'b1, '0);
      i_host.send(SPLK_OP_G_PROG, 4'h3, 1'b0, '0);
      chk("prot3", sector_protected, 16'h0008);
      arr(4'h3, 1'b0);
      arr(4'h4, 1'b1);
      range_protect = 16'h0010;
      arr(4'h4, 1'b0);
      range_protect = '0;
      i_host.send(SPLK_OP_G_ERASE, '0, 1'b0, '0);
      chk("erase", persistent_sector_guard, GUARD_ERASED);
      i_host.send(SPLK_OP_G_PROG, 4'h3, 1'b0, '0);
      i_host.send(SPLK_OP_LK_CLR, '0, 1'b0, '0);
      chk("lock clr", guard_lock, 1'b0);
      i_host.send(SPLK_OP_G_ERASE, '0, 1'b0, '0);
      chk("locked", persistent_sector_guard, 16'hfff7);
      chk("locked err", prog_err, 1'b1);
      i_host.send(SPLK_OP_UNLOCK, '0, 1'b0, PASS_BLANK);
      i_host.send(SPLK_OP_VG_WR, 4'h7, 1'b0, '0);
      chk("no relock", guard_lock, 1'b0);
      pulse(sw_rst);
      chk("sw lock", guard_lock, 1'b0);
      chk("sw vguard", volatile_sector_guard, VGUARD_RST);
      i_host.send(SPLK_OP_PW_PROG, '0, 1'b0, 64'h0123_4567_89ab_cdef);
      i_host.send(SPLK_OP_PW_PROG, '0, 1'b0, 64'hffff_ffff_0000_ffff);
      i_host.send(SPLK_OP_PW_READ, '0, 1'b0, '0);
      chk("pass", pass_rd_data, pw);
      chk("pass err", prog_err, 1'b0);
      i_host.send(SPLK_OP_METHOD, '0, 1'b0, 64'h0);
      chk("illegal", protection_method_reg, METHOD_NONE);
      chk("illegal err", prog_err, 1'b1);
      i_host.send(SPLK_OP_METHOD, '0, 1'b0, 64'h1);
      chk("passwd", protection_method_reg, METHOD_PASSWD);
      i_host.send(SPLK_OP_METHOD, '0, 1'b0, 64'h3);
      chk("otp", protection_method_reg, METHOD_PASSWD);
      i_host.send(SPLK_OP_PW_READ, '0, 1'b0, '0);
      chk("hidden", pass_rd_data, 64'h0);
      i_host.send(SPLK_OP_PW_PROG, '0, 1'b0, 64'h0);
      hw_reset(1'b0);
      chk("pw lock", guard_lock, 1'b0);
      chk("pg kept", persistent_sector_guard, 16'hfff7);
      i_host.send(SPLK_OP_UNLOCK, '0, 1'b0, pw ^ 64'h8000_0000_0000_0000);
      chk("bad busy", busy_flag, 1'b1);
      chk("bad err", prog_err, 1'b1);
      n = 0;
      while (busy_flag === 1'b1 && n < 100) begin
         n++;
         @(posedge mclk) #1;
      end
      chk("delay", n, UCYC);
      chk("bad done", cmd_done, 1'b1);
      chk("bad lock", guard_lock, 1'b0);
      i_host.send(SPLK_OP_UNLOCK, '0, 1'b0, pw);
      chk("unlock", guard_lock, 1'b1);
      chk("no delay", busy_flag, 1'b0);
      chk("ecc eff", ecc_sector_eff, 4'h5);
      chk("ecc ok", ecc_allowed, 1'b1);
      read_protect = 1'b1;
      #1 chk("ecc boot", ecc_sector_eff, BOOT_SECTOR);
      chk("ecc deny", ecc_allowed, 1'b0);
      ecc_sector = BOOT_SECTOR;
      #1 chk("ecc boot ok", ecc_allowed, 1'b1);
      final_report();
   end
endmodule : tb_top
